// [hdl/ssw_top.sv]
// supply supervision and stop-mode watchdog disabling
// Operation
// - arm bits set only in normal, ordered
// - sequence error clears second arming bit
// - stop trigger or normal restarts watchdog
// - new sequence clears first bit; needs second
// - bus wake in stop starts watchdog
// - bus wake start bit written in normal
// - can wake in stop, sleep or fail-safe raises interrupt, pulls rxd low
// - power-on sets flag, holds reset low
// - battery below por resets everything
// - battery undervoltage flag, clear when gone
// - undervoltage suspends short-circuit detection
// - stop suspends battery monitoring unless loaded
// - battery overvoltage flag persists until cleared
// - prewarning sets only warning flag
// - reset threshold drop enters restart
// - hysteresis bit uses highest rising threshold
// - no main flags in sleep
// - overvoltage flag; optional restart with fail
// - overvoltage with config zero enters fail-safe
// - short circuit switches regulator off, fail-safe
// - second regulator and transceiver undervoltage flags
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ssw_top #(
  parameter int RD_CYC    = ssw_pkg::TRD1_CYC,
  parameter int SC_CYC    = ssw_pkg::TSC_CYC,
  parameter int BLANK_CYC = ssw_pkg::TBLANK_CYC
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [ssw_pkg::APB_AW-1:0]  paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output logic      [31:0]                 prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic                        vs_por_ok_i,
  input  wire logic                        battery_under_flag_i,
  input  wire logic                        battery_over_flag_i,
  input  wire logic                        main_regulator_pw_i,
  input  wire logic                        main_regulator_below_rt_i,
  input  wire logic                        main_regulator_above_rtr_i,
  input  wire logic                        main_regulator_above_rt1r_i,
  input  wire logic                        main_supply_over_flag_i,
  input  wire logic                        peak_load_i,
  input  wire logic                        chg_pump_on_i,
  input  wire logic                        second_reg_under_flag_i,
  input  wire logic                        transceiver_supply_under_flag_i,
  input  wire logic                        can_wake_i,
  input  wire logic                        config_state_i,
  output logic                             reset_out_n_o,
  output logic                             fail_output_pin_o,
  output logic                             main_regulator_en_o,
  output logic                             second_regulator_en_o,
  output logic                             can_en_o,
  output logic                             can_rxd_low_o,
  output logic                             wake_irq_o,
  output logic                             wdog_stop_off_o,
  output logic                             long_window_o,
  output logic      [2:0]                  mode_o
);
  import ssw_pkg::*;

  if (RD_CYC < 1 || SC_CYC < 1 || BLANK_CYC < 1) begin : g_chk
    $error("ssw_top: cycle counts must be at least one");
  end

  // two-flop synchronisers for all analog and pin inputs
  logic [13:0] s1_q;
  logic [13:0] s2_q;
  always_ff @(posedge mclk_i) begin
    s1_q <= {vs_por_ok_i, battery_under_flag_i, battery_over_flag_i, main_regulator_pw_i, main_regulator_below_rt_i,
             main_regulator_above_rtr_i, main_regulator_above_rt1r_i, main_supply_over_flag_i, peak_load_i,
             chg_pump_on_i, second_reg_under_flag_i, transceiver_supply_under_flag_i, can_wake_i,
             config_state_i};
    s2_q <= s1_q;
  end
  logic por_ok, battery_under_flag, battery_over_flag, pw, below_rt, above_rtr, above_rt1r, ov;
  logic peak, cp_on, v2_uv, vc_uv, can_wk, cfg;
  assign {por_ok, battery_under_flag, battery_over_flag, pw, below_rt, above_rtr, above_rt1r, ov,
          peak, cp_on, v2_uv, vc_uv, can_wk, cfg} = s2_q;

  // supply power-on reset or battery below por falling threshold
  logic sys_rst;
  assign sys_rst = !rst_n_i || !por_ok;

  logic                 arm_a_q, arm_b_q, bwake_q, wdoff_q, long_q;
  logic                 hys_q, ovrst_q, vcc2on_q, canon_q;
  logic                 reset_q, vcc1en_q, uvc_q, ovc_q, irq_q;
  logic [NFLAG-1:0]     flags_q;
  ssw_mode_t            mode_q;
  logic [31:0]          rd_cnt_q, sc_cnt_q, bl_cnt_q;
  logic                 wk_prev_q, ov_prev_q;
  logic                 pready_q, pslverr_q;
  logic [31:0]          prdata_q;

  // apb slave, no wait states: pready rises in the access phase
  logic        setup, wr, hit;
  logic [31:0] rdval;
  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pready_q && pwrite_i;
  always_comb begin
    hit   = 1'b1;
    rdval = 32'h0;
    case (paddr_i)
      A_WAKE: begin
        rdval[B_ARM_A] = arm_a_q;
        rdval[B_BWAKE] = bwake_q;
      end
      A_WDOG: rdval[B_ARM_B] = arm_b_q;
      A_MODE: begin
        rdval[2:0]     = mode_q;
        rdval[B_WDOFF] = wdoff_q;
      end
      A_SUP: begin
        rdval[B_HYS]    = hys_q;
        rdval[B_OVRST]  = ovrst_q;
        rdval[B_VCC2ON] = vcc2on_q;
        rdval[B_CANON]  = canon_q;
      end
      A_STAT:  rdval[NFLAG-1:0] = flags_q;
      default: hit = 1'b0;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !hit;
        prdata_q  <= pwrite_i ? 32'h0 : rdval;
      end
    end
  end

  logic wr_wake, wr_wdog, wr_mode, wr_sup, wr_stat;
  assign wr_wake = wr && paddr_i == A_WAKE;
  assign wr_wdog = wr && paddr_i == A_WDOG;
  assign wr_mode = wr && paddr_i == A_MODE;
  assign wr_sup  = wr && paddr_i == A_SUP;
  assign wr_stat = wr && paddr_i == A_STAT;

  // events
  logic in_norm, in_stop, wake_rise, ov_ev, ov_fs, ov_rs, uv_ev;
  logic sc_run, sc_fire, rel_ok, release_ev, seq_err, wd_restart;
  logic bw_start, go_norm, mon, ovmon;
  assign in_norm   = mode_q == M_NORMAL;
  assign in_stop   = mode_q == M_STOP;
  assign wake_rise = can_wk && !wk_prev_q;
  assign ov_ev     = vcc1en_q && ov && !ov_prev_q;
  assign ov_fs     = ov_ev && ovrst_q && !cfg;
  assign ov_rs     = ov_ev && ovrst_q && cfg;
  assign uv_ev     = vcc1en_q && below_rt && (in_norm || in_stop);
  assign sc_run    = vcc1en_q && below_rt && !battery_under_flag;
  assign sc_fire   = sc_run && sc_cnt_q == 32'(SC_CYC - 1);
  assign go_norm   = wr_mode && pwdata_i[2:0] == M_NORMAL;
  always_comb begin
    if (mode_q == M_INIT)
      rel_ok = above_rt1r;
    else if (ovc_q)
      rel_ok = 1'b1;
    else
      rel_ok = hys_q ? above_rt1r : above_rtr;
  end
  assign release_ev = (mode_q == M_INIT || mode_q == M_RESTART) && rel_ok
                      && rd_cnt_q == 32'(RD_CYC - 1);
  assign seq_err = (wr_wake && pwdata_i[B_ARM_A]
                    && (!arm_b_q || !in_norm))
                || (wr_wdog && pwdata_i[B_ARM_B] && !in_norm);
  assign wd_restart = in_stop && wdoff_q && (wr_wdog || go_norm);
  assign bw_start   = in_stop && wdoff_q && bwake_q && wake_rise;
  assign mon   = mode_q == M_INIT || mode_q == M_RESTART || in_norm
              || (in_stop && (peak || pw));
  assign ovmon = mon || cp_on;

  // edge history
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      wk_prev_q <= 1'b0;
      ov_prev_q <= 1'b0;
    end else begin
      wk_prev_q <= can_wk;
      ov_prev_q <= ov;
    end
  end

  // arming bits of the stop-mode watchdog disabling sequence
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      arm_a_q <= 1'b0;
      arm_b_q <= 1'b0;
      bwake_q <= BWAKE_RST;
    end else if (wd_restart) begin
      arm_a_q <= 1'b0;
      arm_b_q <= 1'b0;
    end else if (seq_err) begin
      arm_b_q <= 1'b0;
    end else begin
      if (wr_wdog && in_norm) begin
        arm_b_q <= pwdata_i[B_ARM_B];
        if (pwdata_i[B_ARM_B] && arm_a_q)
          arm_a_q <= 1'b0;
      end
      if (wr_wake && in_norm) begin
        arm_a_q <= pwdata_i[B_ARM_A];
        bwake_q <= pwdata_i[B_BWAKE];
      end
    end
  end

  // watchdog state towards the watchdog timer
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      wdoff_q <= 1'b0;
      long_q  <= 1'b0;
    end else begin
      long_q <= wd_restart || bw_start || release_ev;
      if (wd_restart || bw_start || !in_stop && mode_q != M_NORMAL)
        wdoff_q <= 1'b0;
      else if (in_norm && wr_mode && pwdata_i[2:0] == M_STOP)
        wdoff_q <= arm_a_q && arm_b_q;
    end
  end

  // supply control register
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      hys_q    <= 1'b0;
      ovrst_q  <= 1'b0;
      vcc2on_q <= 1'b0;
      canon_q  <= 1'b0;
    end else begin
      if (wr_sup) begin
        hys_q    <= pwdata_i[B_HYS];
        vcc2on_q <= pwdata_i[B_VCC2ON];
        canon_q  <= pwdata_i[B_CANON];
      end
      if (ov_rs)
        ovrst_q <= 1'b0;
      else if (wr_sup)
        ovrst_q <= pwdata_i[B_OVRST];
    end
  end

  // reset delay, short-circuit and blanking counters
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      rd_cnt_q <= 32'h0;
      sc_cnt_q <= 32'h0;
      bl_cnt_q <= 32'h0;
    end else begin
      if ((mode_q == M_INIT || mode_q == M_RESTART) && rel_ok
          && !release_ev)
        rd_cnt_q <= rd_cnt_q + 32'h1;
      else
        rd_cnt_q <= 32'h0;
      if (!sc_run || sc_fire)
        sc_cnt_q <= 32'h0;
      else
        sc_cnt_q <= sc_cnt_q + 32'h1;
      if (!vcc2on_q)
        bl_cnt_q <= 32'h0;
      else if (bl_cnt_q != 32'(BLANK_CYC))
        bl_cnt_q <= bl_cnt_q + 32'h1;
    end
  end

  // mode sequencing, reset output and main regulator enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      mode_q   <= M_INIT;
      reset_q  <= 1'b0;
      vcc1en_q <= 1'b1;
      uvc_q    <= 1'b0;
      ovc_q    <= 1'b0;
    end else if (sc_fire) begin
      mode_q   <= M_FAILSAFE;
      vcc1en_q <= 1'b0;
      reset_q  <= 1'b0;
    end else begin
      case (mode_q)
        M_INIT, M_RESTART: begin
          if (release_ev) begin
            mode_q  <= M_NORMAL;
            reset_q <= 1'b1;
            uvc_q   <= 1'b0;
            ovc_q   <= 1'b0;
          end
        end
        M_NORMAL, M_STOP: begin
          if (ov_fs) begin
            mode_q  <= M_FAILSAFE;
            reset_q <= 1'b0;
          end else if (uv_ev) begin
            mode_q  <= M_RESTART;
            reset_q <= 1'b0;
            uvc_q   <= 1'b1;
          end else if (ov_rs) begin
            mode_q  <= M_RESTART;
            reset_q <= 1'b0;
            ovc_q   <= 1'b1;
          end else if (go_norm && in_stop) begin
            mode_q <= M_NORMAL;
          end else if (wr_mode && in_norm) begin
            if (pwdata_i[2:0] == M_STOP)
              mode_q <= M_STOP;
            else if (pwdata_i[2:0] == M_SLEEP) begin
              mode_q   <= M_SLEEP;
              vcc1en_q <= 1'b0;
              reset_q  <= 1'b0;
            end
          end
        end
        M_SLEEP, M_FAILSAFE: begin
          if (wake_rise) begin
            mode_q   <= M_RESTART;
            vcc1en_q <= 1'b1;
          end
        end
        default: mode_q <= M_INIT;
      endcase
    end
  end

  // status flags: hardware set wins over a clearing write
  logic [NFLAG-1:0] fset, fclr_ok;
  always_comb begin
    fset          = '0;
    fset[F_BUV]   = mon && battery_under_flag;
    fset[F_BOV]   = ovmon && battery_over_flag;
    fset[F_WARN]  = vcc1en_q && mode_q != M_SLEEP && pw;
    fset[F_UV]    = release_ev && uvc_q;
    fset[F_OV]    = ov_ev;
    fset[F_SC]    = sc_fire;
    fset[F_V2UV]  = vcc2on_q && bl_cnt_q == 32'(BLANK_CYC) && v2_uv;
    fset[F_VCUV]  = canon_q && vc_uv;
    fset[F_FAIL]  = sc_fire || ov_fs || ov_rs;
    fset[F_WAKE]  = wake_rise && (in_stop || mode_q == M_SLEEP
                                  || mode_q == M_FAILSAFE);
    fclr_ok        = '1;
    fclr_ok[F_BUV] = !battery_under_flag;
    fclr_ok[F_BOV] = !battery_over_flag;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RST;
      irq_q   <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~(wr_stat ? pwdata_i[NFLAG-1:0] & fclr_ok
                              : '0)) | fset;
      irq_q   <= fset[F_WAKE];
    end
  end

  assign prdata_o          = prdata_q;
  assign pready_o          = pready_q;
  assign pslverr_o         = pslverr_q;
  assign reset_out_n_o     = reset_q;
  assign fail_output_pin_o = flags_q[F_FAIL];
  assign main_regulator_en_o         = vcc1en_q;
  assign second_regulator_en_o         = vcc2on_q;
  assign can_en_o          = canon_q;
  assign can_rxd_low_o     = flags_q[F_WAKE];
  assign wake_irq_o        = irq_q;
  assign wdog_stop_off_o   = wdoff_q;
  assign long_window_o     = long_q;
  assign mode_o            = mode_q;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst);

  sequence s_wake_in_stop_off;
    in_stop && wdoff_q && bwake_q && wake_rise;
  endsequence
  sequence s_wdog_restarted;
    long_window_o && !wdog_stop_off_o;
  endsequence

  a_arm_a_order: assert property (
    $rose(arm_a_q) |-> $past(arm_b_q) && $past(in_norm))
    else $error("first arm bit set without second");
  a_seq_err_clear: assert property (
    seq_err && !wd_restart |=> !arm_b_q)
    else $error("sequence error did not clear second arm bit");
  a_stop_reenable: assert property (
    wd_restart |=> s_wdog_restarted ##0 (!arm_a_q && !arm_b_q))
    else $error("watchdog not restarted from stop");
  a_bus_wake_start: assert property (
    s_wake_in_stop_off |=> s_wdog_restarted)
    else $error("bus wake did not start watchdog");
  a_bwake_lock: assert property (
    !in_norm |=> $stable(bwake_q))
    else $error("bus wake start bit changed outside normal");
  a_wake_signal: assert property (
    fset[F_WAKE] |=> wake_irq_o && can_rxd_low_o ##1 !wake_irq_o)
    else $error("can wake not signalled");
  a_por_hold: assert property (
    $rose(reset_out_n_o) |-> $past(rd_cnt_q) == 32'(RD_CYC - 1))
    else $error("reset released before delay");
  a_uv_restart: assert property (
    uv_ev && !sc_fire && !ov_fs |=> mode_q == M_RESTART && !reset_out_n_o)
    else $error("undervoltage did not enter restart");
  a_short_react: assert property (
    sc_fire |=> mode_q == M_FAILSAFE && !main_regulator_en_o && fail_output_pin_o
                && flags_q[F_SC])
    else $error("short circuit reaction missing");
  a_sleep_noflag: assert property (
    mode_q == M_SLEEP && !flags_q[F_WARN] |=> !flags_q[F_WARN])
    else $error("warning flag set in sleep");
  a_ov_failsafe: assert property (
    ov_fs && !sc_fire |=> mode_q == M_FAILSAFE ##0 fail_output_pin_o)
    else $error("overvoltage fail-safe missing");

endmodule
`default_nettype wire

// [hdl/ssw_pkg.sv]
// constants and types of the supply supervision block
package ssw_pkg;

  // clock and times
  localparam int CLK_MHZ    = 25;
  localparam int TRD1_US    = 10000;
  localparam int TSC_US     = 4000;
  localparam int TBLANK_US  = 500;
  localparam int TRD1_CYC   = TRD1_US * CLK_MHZ;
  localparam int TSC_CYC    = TSC_US * CLK_MHZ;
  localparam int TBLANK_CYC = TBLANK_US * CLK_MHZ;

  // apb map
  localparam int        APB_AW     = 8;
  localparam bit [7:0]  A_WAKE     = 8'h00;
  localparam bit [7:0]  A_WDOG     = 8'h04;
  localparam bit [7:0]  A_MODE     = 8'h08;
  localparam bit [7:0]  A_SUP      = 8'h0c;
  localparam bit [7:0]  A_STAT     = 8'h10;

  // wake_control_reg fields
  localparam int        B_ARM_A    = 0;
  localparam int        B_BWAKE    = 1;
  localparam bit        BWAKE_RST  = 1'b1;
  // watchdog_control_reg fields
  localparam int        B_ARM_B    = 0;
  // mode register fields
  localparam int        B_WDOFF    = 3;
  // supply control fields
  localparam int        B_HYS      = 0;
  localparam int        B_OVRST    = 1;
  localparam int        B_VCC2ON   = 2;
  localparam int        B_CANON    = 3;

  // status flags
  localparam int        NFLAG      = 11;
  localparam int        F_POR      = 0;
  localparam int        F_BUV      = 1;
  localparam int        F_BOV      = 2;
  localparam int        F_WARN     = 3;
  localparam int        F_UV       = 4;
  localparam int        F_OV       = 5;
  localparam int        F_SC       = 6;
  localparam int        F_V2UV     = 7;
  localparam int        F_VCUV     = 8;
  localparam int        F_FAIL     = 9;
  localparam int        F_WAKE     = 10;
  localparam bit [10:0] FLAGS_RST  = 11'h001;

  typedef enum logic [2:0] {
    M_INIT     = 3'h0,
    M_NORMAL   = 3'h1,
    M_STOP     = 3'h2,
    M_SLEEP    = 3'h3,
    M_RESTART  = 3'h4,
    M_FAILSAFE = 3'h5
  } ssw_mode_t;

endpackage

// [testbench/ssw_host.sv]
// host model: apb master of the supervision block
`timescale 1ns/1ps
`default_nettype none
module ssw_host (
  input  wire logic        clk_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  import ssw_pkg::*;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          seed;
  initial begin
    seed = 73;
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] x);
    logic rdy;
    if (!w)
      exp_q.push_back(x);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= ($random(seed) & 32'hfffff000) | d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    rdy = 1'b0;
    while (!rdy) begin
      @(posedge clk_i);
      rdy = pready_i;
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b0, a, 32'h0, {1'b0, d});
  endtask
  // bus wake bit first, then both arm bits in order, then stop
  task automatic arm_seq(input logic bw);
    wr(A_WAKE, {30'h0, bw, 1'b0});
    wr(A_WDOG, 32'h1);
    wr(A_WAKE, {30'h0, bw, 1'b1});
    wr(A_MODE, 32'h2);
  endtask
  // read results are compared against the oldest note
  always @(posedge clk_i) begin
    if (psel_o && penable_o && pready_i && !pwrite_o) begin
      if (exp_q.size() > 0)
        e = exp_q.pop_front();
      else
        e = 33'hx;
      test_supply_supervision_wd_stop.cmp($sformatf("read %h", paddr_o),
                                          e, {pslverr_i, prdata_i});
    end
  end
endmodule
`default_nettype wire

// [testbench/test_supply_supervision_wd_stop.sv]
// self-checking bench of the supply supervision block
`timescale 1ns/1ps
`default_nettype none
module test_supply_supervision_wd_stop;
  import ssw_pkg::*;
  localparam int RD = 8;
  localparam int SC = 8;
  localparam int BL = 4;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por = 1'b1;
  logic [4:0]  flt = 5'h0;
  logic        below = 1'b0;
  logic        rtr = 1'b1;
  logic        rt1r = 1'b1;
  logic        ov = 1'b0;
  logic        cwk = 1'b0;
  logic        cfg = 1'b1;
  logic        peak = 1'b0;
  logic        cp = 1'b0;
  logic        psel, pen, pwr, rdy, serr;
  logic [7:0]  paddr;
  logic [31:0] pwd, prd;
  logic        reset_out_n, fail, v1en, v2en, cen, rxd, irq, woff, lw;
  logic [2:0]  mode;
  wire  logic [9:0] obs = {cen, v2en, fail, v1en, reset_out_n, rxd, woff, mode};
  int          err_total = 0;
  int          checks_done = 0;
  int          lw_n = 0;
  int          irq_n = 0;
  int          n, k, i;
  int          fb[5] = '{1, 2, 3, 7, 8};

  always #20 mclk = ~mclk;

  ssw_top #(.RD_CYC(RD), .SC_CYC(SC), .BLANK_CYC(BL)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(serr), .vs_por_ok_i(por),
    .battery_under_flag_i(flt[0]), .battery_over_flag_i(flt[1]), .main_regulator_pw_i(flt[2]),
    .main_regulator_below_rt_i(below), .main_regulator_above_rtr_i(rtr),
    .main_regulator_above_rt1r_i(rt1r), .main_supply_over_flag_i(ov), .peak_load_i(peak),
    .chg_pump_on_i(cp), .second_reg_under_flag_i(flt[3]), .transceiver_supply_under_flag_i(flt[4]),
    .can_wake_i(cwk), .config_state_i(cfg), .reset_out_n_o(reset_out_n),
    .fail_output_pin_o(fail), .main_regulator_en_o(v1en), .second_regulator_en_o(v2en),
    .can_en_o(cen), .can_rxd_low_o(rxd), .wake_irq_o(irq),
    .wdog_stop_off_o(woff), .long_window_o(lw), .mode_o(mode));

  ssw_host h (.clk_i(mclk), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd), .prdata_i(prd),
    .pready_i(rdy), .pslverr_i(serr));

  // pulse outputs are counted in the cycle they stand
  always @(negedge mclk) begin
    if (lw === 1'b1)
      lw_n++;
    if (irq === 1'b1)
      irq_n++;
  end

  task automatic cmp(input string nm, input logic [32:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input string nm, input logic [9:0] m, e, input int t);
    int c;
    c = 0;
    @(negedge mclk);
    while ((obs & m) !== e && c < t) begin
      @(negedge mclk);
      c++;
    end
    cmp(nm, {23'h0, e}, {23'h0, obs & m});
    @(posedge mclk);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic cw();
    @(posedge mclk);
    cwk <= 1'b1;
    cyc(4);
    cwk <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    cyc(12);
    rst_n <= 1'b1;
    wt("reset_out_n up", 10'h027, 10'h021, RD + 40);
    h.rd(A_STAT, 32'h001);
    h.rd(A_WAKE, 32'h002);
    h.xfer(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    h.wr(A_STAT, 32'h7ff);
    h.wr(A_WAKE, 32'h003);
    h.rd(A_WAKE, 32'h002);
    h.wr(A_WDOG, 32'h001);
    h.wr(A_WAKE, 32'h003);
    h.wr(A_WDOG, 32'h001);
    h.rd(A_WAKE, 32'h002);
    h.wr(A_MODE, 32'h002);
    wt("stop armed b", 10'h00f, 10'h002, 8);
    @(posedge mclk);
    flt[0] <= 1'b1;
    cyc(8);
    h.rd(A_STAT, 32'h0);
    peak <= 1'b1;
    cyc(8);
    h.rd(A_STAT, 32'h002);
    peak <= 1'b0;
    flt[0] <= 1'b0;
    cp <= 1'b1;
    flt[1] <= 1'b1;
    cyc(8);
    h.wr(A_STAT, 32'h7ff);
    cp <= 1'b0;
    cyc(8);
    h.rd(A_STAT, 32'h004);
    flt[1] <= 1'b0;
    cyc(8);
    h.wr(A_STAT, 32'h7ff);
    h.rd(A_STAT, 32'h0);
    h.wr(A_WAKE, 32'h001);
    h.rd(A_WDOG, 32'h0);
    h.rd(A_WAKE, 32'h002);
    cyc(4);
    h.wr(A_MODE, 32'h001);
    h.arm_seq(1'b1);
    wt("wdog off", 10'h00f, 10'h00a, 8);
    h.rd(A_MODE, 32'h00a);
    n = lw_n;
    h.wr(A_WDOG, 32'h0);
    wt("trigger on", 10'h008, 10'h000, 8);
    cmp("long window", 33'(n + 1), 33'(lw_n));
    h.rd(A_WAKE, 32'h002);
    h.rd(A_WDOG, 32'h0);
    h.wr(A_MODE, 32'h001);
    h.arm_seq(1'b1);
    wt("wdog off", 10'h00f, 10'h00a, 8);
    n = lw_n;
    h.wr(A_MODE, 32'h001);
    wt("normal on", 10'h00f, 10'h001, 8);
    cmp("long window", 33'(n + 1), 33'(lw_n));
    h.arm_seq(1'b1);
    wt("wdog off", 10'h00f, 10'h00a, 8);
    n = lw_n;
    k = irq_n;
    cw();
    wt("bus wake", 10'h018, 10'h010, 12);
    cmp("long window", 33'(n + 1), 33'(lw_n));
    cmp("wake irq", 33'(k + 1), 33'(irq_n));
    h.rd(A_STAT, 32'h400);
    h.wr(A_STAT, 32'h400);
    wt("rxd free", 10'h010, 10'h000, 4);
    h.wr(A_MODE, 32'h001);
    h.arm_seq(1'b0);
    wt("wdog off", 10'h00f, 10'h00a, 8);
    n = lw_n;
    cw();
    cyc(12);
    cmp("no start", 33'(n), 33'(lw_n));
    wt("still off", 10'h008, 10'h008, 1);
    h.wr(A_MODE, 32'h001);
    wt("normal", 10'h007, 10'h001, 8);
    h.wr(A_STAT, 32'h7ff);
    h.wr(A_SUP, 32'h00c);
    wt("supplies on", 10'h300, 10'h300, 4);
    cyc(BL + 8);
    for (i = 0; i < 5; i++) begin
      @(posedge mclk);
      flt[i] <= 1'b1;
      cyc(8);
      h.rd(A_STAT, 32'h1 << fb[i]);
      wt("flag only", 10'h027, 10'h021, 1);
      h.wr(A_STAT, 32'h7ff);
      h.rd(A_STAT, 32'h1 << fb[i]);
      @(posedge mclk);
      flt[i] <= 1'b0;
      cyc(8);
      h.wr(A_STAT, 32'h7ff);
      h.rd(A_STAT, 32'h0);
    end
    h.wr(A_SUP, 32'h00e);
    @(posedge mclk);
    ov <= 1'b1;
    wt("ov restart", 10'h0a7, 10'h084, 12);
    wt("ov resume", 10'h027, 10'h021, RD + 20);
    ov <= 1'b0;
    h.rd(A_SUP, 32'h00c);
    h.rd(A_STAT, 32'h220);
    h.wr(A_STAT, 32'h7ff);
    cfg <= 1'b0;
    h.wr(A_SUP, 32'h00e);
    @(posedge mclk);
    ov <= 1'b1;
    wt("ov failsafe", 10'h087, 10'h085, 12);
    ov <= 1'b0;
    cw();
    wt("wake up", 10'h027, 10'h021, RD + 40);
    h.wr(A_STAT, 32'h7ff);
    h.wr(A_SUP, 32'h00d);
    @(posedge mclk);
    flt[0] <= 1'b1;
    below <= 1'b1;
    rtr <= 1'b0;
    rt1r <= 1'b0;
    wt("uv reset", 10'h027, 10'h004, 8);
    cyc(3 * SC);
    wt("no short", 10'h0c7, 10'h044, 1);
    below <= 1'b0;
    rtr <= 1'b1;
    cyc(2 * RD + 8);
    wt("hys holds", 10'h027, 10'h004, 1);
    rt1r <= 1'b1;
    wt("uv release", 10'h027, 10'h021, RD + 10);
    h.rd(A_STAT, 32'h012);
    flt[0] <= 1'b0;
    cyc(8);
    h.wr(A_STAT, 32'h7ff);
    below <= 1'b1;
    rtr <= 1'b0;
    rt1r <= 1'b0;
    wt("short", 10'h0c7, 10'h085, SC + 40);
    h.rd(A_STAT, 32'h240);
    below <= 1'b0;
    rtr <= 1'b1;
    rt1r <= 1'b1;
    cw();
    wt("wake up", 10'h027, 10'h021, RD + 40);
    h.wr(A_STAT, 32'h7ff);
    h.wr(A_MODE, 32'h003);
    wt("sleep", 10'h007, 10'h003, 8);
    flt[2] <= 1'b1;
    cyc(8);
    h.rd(A_STAT, 32'h0);
    flt[2] <= 1'b0;
    por <= 1'b0;
    cyc(4);
    wt("por reset", 10'h027, 10'h000, 4);
    por <= 1'b1;
    wt("por up", 10'h027, 10'h021, RD + 40);
    h.rd(A_STAT, 32'h001);
    h.rd(A_SUP, 32'h0);
    stop_test();
  end

  initial begin
    cyc(20000);
    err_total++;
    $display("mismatch watchdog expected done seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
